// ==== ars_defs.svh ====
// offsets, field positions, reset values and timing counts for the
// auto restart sequencer; included from the design only, the package does not include it
`ifndef ARS_DEFS_SVH
`define ARS_DEFS_SVH
// register byte offsets, decoded on haddr[7:0]
`define ARS_ADDR_CFG 8'h00
`define ARS_ADDR_DELAY 8'h04
`define ARS_ADDR_CMD 8'h08
`define ARS_ADDR_STATUS 8'h0c
`define ARS_ADDR_IRQ_STAT 8'h10
`define ARS_ADDR_IRQ_MASK 8'h14
// cfg and cmd fields
`define ARS_CFG_MODE_LSB 0
`define ARS_CFG_3W_BIT 4
`define ARS_CFG_LIM_LSB 8
`define ARS_CMD_FRST_BIT 0
// reset values and limits
`define ARS_MODE_RST 2'h1
`define ARS_LIMIT_RST 4'h3
`define ARS_LIMIT_MAX 4'ha
`define ARS_DELAY_RST 12'h003
`define ARS_DELAY_MAX 12'he10
// interrupt status bits
`define ARS_EV_FAULT 0
`define ARS_EV_ATTEMPT 1
`define ARS_EV_LIMIT 2
`define ARS_EV_START 3
`define ARS_EV_W 4
// timing
`define ARS_CLK_PERIOD_NS 5
`define ARS_SECOND_NS 1000000000
`define ARS_HOUR_S 3600
`define ARS_SETTLE_CYC 3'h4
`define ARS_CHECK_CYC 3'h4
`endif

// ==== ars_pkg.sv ====
// types shared by the auto restart sequencer
// assumes ars_defs.svh is on the include path
`default_nettype none
package ars_pkg;
  typedef enum logic [1:0] {
    ARS_MODE_MANUAL,
    ARS_MODE_POWERUP,
    ARS_MODE_AFTER_FAULT,
    ARS_MODE_BOTH
  } ars_mode_t;

  typedef enum logic [2:0] {
    ARS_ST_INIT,
    ARS_ST_IDLE,
    ARS_ST_WAIT_REL,
    ARS_ST_RUN,
    ARS_ST_DELAY,
    ARS_ST_CHECK,
    ARS_ST_HOLD
  } ars_state_t;

  typedef struct packed {
    logic three_wire;
    ars_mode_t mode;
    logic [3:0] restart_limit_setting;
    logic [11:0] delay_s;
  } ars_cfg_t;
endpackage
`default_nettype wire

// ==== ars_sequencer.sv ====
// auto restart sequencer: run/fault supervisor with ahb-lite registers
// assumes one 200 mhz clock, async active-low reset, pins asynchronous
//
// Summary of operation
// - manual mode: run present at power-up is ignored until removed, reapplied
// - run command is enable together with forward or reverse
// - manual mode: after fault, needs fault reset and run cycled
// - manual mode: limit zero waits manual reset, else auto reset, run cycle
// - power-up mode: auto start at power-up, never auto restart after fault
// - after-fault mode: no power-up start; after delay auto reset, resume
// - combined mode: auto start at power-up and after faults
// - three-wire wiring: no auto start after fault or power loss
// - auto attempts capped by 0..10 limit, default 3; then manual restart
// - attempt count clears after an hour below limit and on power-up
// - restart delay 0..3600 seconds, default 3
// - after delay, fault reset; run if it clears, else new delay
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`include "ars_defs.svh"
`default_nettype none
module ars_sequencer #(
  parameter int unsigned CYC_PER_SEC = `ARS_SECOND_NS / `ARS_CLK_PERIOD_NS,
  parameter int unsigned SEC_PER_HOUR = `ARS_HOUR_S
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_direction_forward_in,
  input wire logic i_direction_reverse_in,
  input wire logic i_fault,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_run,
  output logic o_fault_reset,
  output logic o_irq
);
  // pin synchronisers: stage one feeds stage two only
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {i_fault, i_direction_reverse_in,
                   i_direction_forward_in, i_enable};
      pin_s2_r <= pin_s1_r;
    end
  end

  wire logic run_cmd = pin_s2_r[0] & (pin_s2_r[1] | pin_s2_r[2]);
  wire logic fault = pin_s2_r[3];

  // second and hour prescalers
  logic [31:0] sec_cnt_r;
  logic sec_tick_r;
  logic [11:0] hour_cnt_r;
  wire logic sec_wrap = sec_cnt_r == CYC_PER_SEC - 32'h1;
  wire logic hour_tick = sec_tick_r &&
                         hour_cnt_r == 12'(SEC_PER_HOUR - 1);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sec_cnt_r <= 32'h0;
      sec_tick_r <= 1'b0;
      hour_cnt_r <= 12'h0;
    end else begin
      sec_cnt_r <= sec_wrap ? 32'h0 : sec_cnt_r + 32'h1;
      sec_tick_r <= sec_wrap;
      if (sec_tick_r)
        hour_cnt_r <= hour_tick ? 12'h0 : hour_cnt_r + 12'h1;
    end
  end

  // ahb-lite slave: writes zero-wait, reads take one wait state so
  // that read data always reflects a write in the previous data phase
  ars_pkg::ars_cfg_t cfg_r;
  logic [`ARS_EV_W-1:0] irq_stat_r;
  logic [`ARS_EV_W-1:0] irq_mask_r;
  logic [7:0] addr_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  wire logic acc = i_hsel & i_htrans[1] & i_hready & (i_hsize == 3'h2);
  wire logic wr_cfg = wr_pend_r && addr_r == `ARS_ADDR_CFG;
  wire logic wr_dly = wr_pend_r && addr_r == `ARS_ADDR_DELAY;
  wire logic wr_cmd = wr_pend_r && addr_r == `ARS_ADDR_CMD;
  wire logic wr_ist = wr_pend_r && addr_r == `ARS_ADDR_IRQ_STAT;
  wire logic wr_imk = wr_pend_r && addr_r == `ARS_ADDR_IRQ_MASK;
  wire logic man_rst = wr_cmd & i_hwdata[`ARS_CMD_FRST_BIT];
  wire logic [3:0] lim_wr = i_hwdata[`ARS_CFG_LIM_LSB +: 4];
  wire logic [11:0] dly_wr = i_hwdata[11:0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_r <= 8'h0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else begin
      if (acc)
        addr_r <= i_haddr[7:0];
      wr_pend_r <= acc & i_hwrite;
      rd_pend_r <= acc & ~i_hwrite;
    end
  end

  // configuration; out-of-range values saturate at the documented maxima
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r.mode <= ars_pkg::ars_mode_t'(`ARS_MODE_RST);
      cfg_r.three_wire <= 1'b0;
      cfg_r.restart_limit_setting <= `ARS_LIMIT_RST;
      cfg_r.delay_s <= `ARS_DELAY_RST;
      irq_mask_r <= 4'h0;
    end else begin
      if (wr_cfg) begin
        cfg_r.mode <= ars_pkg::ars_mode_t'(i_hwdata[`ARS_CFG_MODE_LSB +: 2]);
        cfg_r.three_wire <= i_hwdata[`ARS_CFG_3W_BIT];
        cfg_r.restart_limit_setting <=
          (lim_wr > `ARS_LIMIT_MAX) ? `ARS_LIMIT_MAX : lim_wr;
      end
      if (wr_dly)
        cfg_r.delay_s <=
          (dly_wr > `ARS_DELAY_MAX) ? `ARS_DELAY_MAX : dly_wr;
      if (wr_imk)
        irq_mask_r <= i_hwdata[`ARS_EV_W-1:0];
    end
  end

  // sequencer
  ars_pkg::ars_state_t st_r;
  ars_pkg::ars_state_t st_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [11:0] dly_r;
  logic [11:0] dly_nxt;
  logic [3:0] att_r;
  logic [3:0] att_nxt;
  logic resume_r;
  logic resume_nxt;
  logic manual_r;
  logic manual_nxt;
  logic frst_nxt;
  logic att_inc;
  logic att_clr;
  logic [`ARS_EV_W-1:0] ev;

  wire ars_pkg::ars_mode_t mode = cfg_r.mode;
  wire logic [3:0] lim = cfg_r.restart_limit_setting;
  wire logic below_lim = att_r < lim;
  // three-wire contacts are open after a fault or power loss
  wire logic auto_pu = (mode == ars_pkg::ARS_MODE_POWERUP ||
                        mode == ars_pkg::ARS_MODE_BOTH) &&
                       !cfg_r.three_wire;
  wire logic auto_af = (mode == ars_pkg::ARS_MODE_AFTER_FAULT ||
                        mode == ars_pkg::ARS_MODE_BOTH) &&
                       !cfg_r.three_wire;
  wire logic can_reset = mode != ars_pkg::ARS_MODE_POWERUP &&
                         below_lim;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    dly_nxt = dly_r;
    resume_nxt = resume_r;
    manual_nxt = manual_r;
    frst_nxt = 1'b0;
    att_inc = 1'b0;
    att_clr = 1'b0;
    ev = 4'h0;
    case (st_r)
      ars_pkg::ARS_ST_INIT: begin
        // wait until the synchronisers show the real pin levels
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == `ARS_SETTLE_CYC) begin
          cnt_nxt = 3'h0;
          if (run_cmd && !fault && auto_pu) begin
            st_nxt = ars_pkg::ARS_ST_RUN;
            ev[`ARS_EV_START] = 1'b1;
          end else if (run_cmd) begin
            st_nxt = ars_pkg::ARS_ST_WAIT_REL;
          end else begin
            st_nxt = ars_pkg::ARS_ST_IDLE;
          end
        end
      end
      ars_pkg::ARS_ST_IDLE: begin
        if (run_cmd && !fault) begin
          st_nxt = ars_pkg::ARS_ST_RUN;
          ev[`ARS_EV_START] = 1'b1;
        end
      end
      ars_pkg::ARS_ST_WAIT_REL: begin
        if (!run_cmd)
          st_nxt = ars_pkg::ARS_ST_IDLE;
      end
      ars_pkg::ARS_ST_RUN: begin
        if (fault) begin
          ev[`ARS_EV_FAULT] = 1'b1;
          resume_nxt = auto_af;
          if (can_reset) begin
            st_nxt = ars_pkg::ARS_ST_DELAY;
            dly_nxt = cfg_r.delay_s;
          end else begin
            st_nxt = ars_pkg::ARS_ST_HOLD;
            ev[`ARS_EV_LIMIT] = lim != 4'h0;
          end
        end else if (!run_cmd) begin
          st_nxt = ars_pkg::ARS_ST_IDLE;
        end
      end
      ars_pkg::ARS_ST_DELAY: begin
        if (dly_r == 12'h0) begin
          st_nxt = ars_pkg::ARS_ST_CHECK;
          frst_nxt = 1'b1;
          att_inc = 1'b1;
          manual_nxt = 1'b0;
          ev[`ARS_EV_ATTEMPT] = 1'b1;
        end else if (sec_tick_r) begin
          dly_nxt = dly_r - 12'h1;
        end
      end
      ars_pkg::ARS_ST_CHECK: begin
        // give the fault logic time to drop its flag after the pulse
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == `ARS_CHECK_CYC) begin
          cnt_nxt = 3'h0;
          if (fault && !manual_r && below_lim) begin
            st_nxt = ars_pkg::ARS_ST_DELAY;
            dly_nxt = cfg_r.delay_s;
          end else if (fault) begin
            st_nxt = ars_pkg::ARS_ST_HOLD;
            ev[`ARS_EV_LIMIT] = !manual_r;
          end else if (resume_r && !manual_r && run_cmd) begin
            st_nxt = ars_pkg::ARS_ST_RUN;
            ev[`ARS_EV_START] = 1'b1;
          end else begin
            st_nxt = ars_pkg::ARS_ST_WAIT_REL;
          end
        end
      end
      ars_pkg::ARS_ST_HOLD: begin
        if (man_rst) begin
          st_nxt = ars_pkg::ARS_ST_CHECK;
          frst_nxt = 1'b1;
          manual_nxt = 1'b1;
          att_clr = 1'b1;
        end
      end
      default: st_nxt = ars_pkg::ARS_ST_INIT;
    endcase
  end

  // hour expiry clears the count only while below the limit
  always_comb begin
    att_nxt = att_r;
    if (att_clr || (hour_tick && below_lim))
      att_nxt = 4'h0;
    if (att_inc)
      att_nxt = att_nxt + 4'h1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ars_pkg::ARS_ST_INIT;
      cnt_r <= 3'h0;
      dly_r <= 12'h0;
      att_r <= 4'h0;
      resume_r <= 1'b0;
      manual_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      dly_r <= dly_nxt;
      att_r <= att_nxt;
      resume_r <= resume_nxt;
      manual_r <= manual_nxt;
    end
  end

  // interrupt status: a new event wins over a same-cycle clear
  wire logic [`ARS_EV_W-1:0] ist_clr =
    wr_ist ? i_hwdata[`ARS_EV_W-1:0] : 4'h0;
  wire logic [`ARS_EV_W-1:0] ist_nxt = (irq_stat_r & ~ist_clr) | ev;
  wire logic [`ARS_EV_W-1:0] imk_nxt =
    wr_imk ? i_hwdata[`ARS_EV_W-1:0] : irq_mask_r;

  wire logic [31:0] status_word = {4'h0, dly_r, 4'h0, 1'b0, st_r,
                                   att_r, 1'b0, run_cmd, fault,
                                   st_r == ars_pkg::ARS_ST_RUN};
  wire logic [31:0] cfg_word = {20'h0, cfg_r.restart_limit_setting,
                                3'h0, cfg_r.three_wire, 2'h0, mode};
  wire logic [31:0] rd_data =
    (addr_r == `ARS_ADDR_CFG) ? cfg_word :
    (addr_r == `ARS_ADDR_DELAY) ? {20'h0, cfg_r.delay_s} :
    (addr_r == `ARS_ADDR_STATUS) ? status_word :
    (addr_r == `ARS_ADDR_IRQ_STAT) ? {28'h0, irq_stat_r} :
    (addr_r == `ARS_ADDR_IRQ_MASK) ? {28'h0, irq_mask_r} : 32'h0;

  logic run_r;
  logic frst_r;
  logic irq_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_r <= 4'h0;
      hrdata_r <= 32'h0;
      hreadyout_r <= 1'b1;
      run_r <= 1'b0;
      frst_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= ist_nxt;
      hreadyout_r <= !(acc && !i_hwrite);
      if (rd_pend_r)
        hrdata_r <= rd_data;
      run_r <= st_nxt == ars_pkg::ARS_ST_RUN;
      frst_r <= frst_nxt;
      irq_r <= |(ist_nxt & imk_nxt);
    end
  end

  assign o_hrdata = hrdata_r;
  assign o_hreadyout = hreadyout_r;
  assign o_hresp = 1'b0;
  assign o_run = run_r;
  assign o_fault_reset = frst_r;
  assign o_irq = irq_r;
endmodule
`default_nettype wire

// ==== ars_seq_assertions.sv ====
// checker for the auto restart sequencer, watching its ports only
// assumes it is bound to ars_sequencer; one clock domain
`default_nettype none
module ars_seq_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_direction_forward_in,
  input wire logic i_direction_reverse_in,
  input wire logic i_fault,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_run,
  input wire logic o_fault_reset
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [3:0] since_r;
  logic [2:0] up_r;
  wire logic cmd = i_enable &&
    (i_direction_forward_in || i_direction_reverse_in);
  wire logic go = i_hsel && i_htrans[1] && i_hready && i_hsize == 3'h2;
  // saturating ages: since the run pins were last seen, since reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      since_r <= 4'hf;
      up_r <= 3'h0;
    end else begin
      since_r <= cmd ? 4'h0 : since_r + {3'h0, since_r != 4'hf};
      up_r <= up_r + {2'h0, up_r != 3'h7};
    end
  end
  a_okay_resp: assert property (!o_hresp)
    else $error("response not okay");
  a_read_wait: assert property (go && !i_hwrite |=>
    !o_hreadyout ##1 o_hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (go && i_hwrite |=> o_hreadyout)
    else $error("write stalled");
  a_rdata_hold: assert property (o_hreadyout && $past(o_hreadyout)
    |-> $stable(o_hrdata)) else $error("read data moved");
  a_reset_pulse: assert property (o_fault_reset |=> !o_fault_reset)
    else $error("fault reset longer than a cycle");
  a_reset_stopped: assert property (o_fault_reset |-> !o_run)
    else $error("fault reset while running");
  a_run_cmd: assert property ($rose(o_run) |-> since_r < 4'h6)
    else $error("run without run command");
  a_fault_stop: assert property (o_run && $rose(i_fault) |->
    ##[1:6] !o_run) else $error("run kept after fault");
  a_early_off: assert property (up_r < 3'h5 |-> !o_run)
    else $error("run before settling");
endmodule
bind ars_sequencer ars_seq_assertions chk_u (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_enable(i_enable), .i_fault(i_fault),
  .i_direction_forward_in(i_direction_forward_in),
  .i_direction_reverse_in(i_direction_reverse_in), .i_hsel(i_hsel),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .o_run(o_run), .o_fault_reset(o_fault_reset));
`default_nettype wire

// ==== ars_drive_model.sv ====
// partner model: operator run pins and the drive's fault logic
// assumes the sequencer clears a fault by pulsing its fault reset
`default_nettype none
module ars_drive_model (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic [1:0] i_dir,
  input wire logic i_fault_req,
  input wire logic i_sticky,
  input wire logic i_slow,
  input wire logic i_fault_reset,
  output logic o_enable,
  output logic o_fwd,
  output logic o_rev,
  output logic o_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] clr_r = 3'h0;
  logic flt_r = 1'b0;
  assign o_enable = i_en;
  assign o_fwd = i_dir[0];
  assign o_rev = i_dir[1];
  assign o_fault = flt_r;
  // a sticky fault survives the reset pulse, so retries must fail
  always @(posedge i_clk) begin
    if (i_fault_reset && !i_sticky)
      clr_r <= i_slow ? 3'h2 : 3'h1;
    else if (clr_r != 3'h0)
      clr_r <= clr_r - 3'h1;
    if (i_fault_req)
      flt_r <= 1'b1;
    else if (clr_r == 3'h1)
      flt_r <= 1'b0;
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// testbench for the auto restart sequencer
// assumes sequencer, drive model and checker are compiled first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
  } ars_tb_row_t;
  localparam ars_tb_row_t ROWS [8] = '{
    '{8'h00, 1'b0, 32'h0, 32'h301}, '{8'h04, 1'b0, 32'h0, 32'h3},
    '{8'h14, 1'b0, 32'h0, 32'h0}, '{8'h08, 1'b0, 32'h0, 32'h0},
    '{8'h00, 1'b1, 32'hf01, 32'ha01}, '{8'h04, 1'b1, 32'hfff, 32'he10},
    '{8'h18, 1'b1, 32'hffffffff, 32'h0}, '{8'h04, 1'b1, 32'h1, 32'h1}};
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic en = 1'b1, fq = 1'b0, stk = 1'b0, slow = 1'b0, hsel = 1'b0;
  logic hwr = 1'b0, got;
  logic [1:0] dir = 2'h1, htr = 2'h0;
  logic [31:0] ha = 32'h0, hwd = 32'h0, q;
  wire logic ena, direction_forward_in, direction_reverse_in, flt, hrdy, run, frst, irq;
  wire logic [31:0] hrd;
  int bad_count = 0, n_compared = 0, np;
  ars_drive_model pm_u (.i_clk(i_clk), .i_en(en), .i_dir(dir),
    .i_fault_req(fq), .i_sticky(stk), .i_slow(slow),
    .i_fault_reset(frst), .o_enable(ena), .o_fwd(direction_forward_in), .o_rev(direction_reverse_in),
    .o_fault(flt));
  // short second and hour keep the run brief
  ars_sequencer #(.CYC_PER_SEC(10), .SEC_PER_HOUR(200)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_enable(ena),
    .i_direction_forward_in(direction_forward_in), .i_direction_reverse_in(direction_reverse_in),
    .i_fault(flt), .i_hsel(hsel), .i_haddr(ha), .i_htrans(htr),
    .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hrdy),
    .o_hrdata(hrd), .o_hreadyout(hrdy), .o_hresp(), .o_run(run),
    .o_fault_reset(frst), .o_irq(irq));
  always #2.5 i_clk = ~i_clk;
  task automatic chk(input string s, input logic [31:0] v, e);
    n_compared++;
    if (v !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", s, e, v);
    end
  endtask
  task automatic final_report();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (hrdy !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    htr <= 2'h2;
    hwr <= w;
    ha <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    rdy();
    q = hrd;
  endtask
  task automatic wrun(input int n, input logic e);
    got = 1'b0;
    repeat (n) begin
      @(negedge i_clk);
      if (run === 1'b1) got = 1'b1;
    end
    chk("run", {31'h0, got}, {31'h0, e});
  endtask
  task automatic npul(input int n, input int e);
    np = 0;
    repeat (n) begin
      @(negedge i_clk);
      if (frst === 1'b1) np++;
    end
    chk("pulses", 32'(np), 32'(e));
  endtask
  task automatic setp(input logic e, input logic [1:0] d);
    @(posedge i_clk);
    en <= e;
    dir <= d;
  endtask
  task automatic cyc();
    setp(1'b1, 2'h0);
    repeat (10) @(posedge i_clk);
    setp(1'b1, 2'h1);
  endtask
  task automatic fpulse();
    @(posedge i_clk);
    fq <= 1'b1;
    @(posedge i_clk);
    fq <= 1'b0;
  endtask
  // run pins stay held across power-up so the start decision sees them
  task automatic por(input logic [31:0] c);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    ahb(1'b1, 8'h00, c);
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) ahb(1'b1, ROWS[i].a, ROWS[i].d);
      ahb(1'b0, ROWS[i].a, 32'h0);
      chk("reg", q, ROWS[i].e);
    end
    wrun(2, 1'b1);
    fpulse();
    npul(80, 0);
    wrun(5, 1'b0);
    ahb(1'b1, 8'h08, 32'h1);
    wrun(30, 1'b0);
    setp(1'b1, 2'h0);
    wrun(15, 1'b0);
    setp(1'b1, 2'h2);
    wrun(20, 1'b1);
    por(32'h300);
    wrun(30, 1'b0);
    cyc();
    wrun(20, 1'b1);
    fpulse();
    npul(80, 1);
    wrun(30, 1'b0);
    por(32'h202);
    wrun(30, 1'b0);
    cyc();
    wrun(20, 1'b1);
    @(posedge i_clk);
    stk <= 1'b1;
    fpulse();
    npul(150, 2);
    wrun(5, 1'b0);
    ahb(1'b0, 8'h10, 32'h0);
    chk("irq_stat", q, 32'hf);
    chk("irq", {31'h0, irq}, 32'h0);
    ahb(1'b1, 8'h14, 32'h4);
    repeat (3) @(negedge i_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    ahb(1'b1, 8'h10, 32'h4);
    repeat (3) @(negedge i_clk);
    chk("irq", {31'h0, irq}, 32'h0);
    ahb(1'b0, 8'h10, 32'h0);
    chk("irq_stat", q, 32'hb);
    stk <= 1'b0;
    ahb(1'b1, 8'h08, 32'h1);
    cyc();
    wrun(20, 1'b1);
    fpulse();
    npul(60, 1);
    wrun(5, 1'b1);
    ahb(1'b0, 8'h0c, 32'h0);
    chk("count", {28'h0, q[7:4]}, 32'h1);
    repeat (2100) @(posedge i_clk);
    ahb(1'b0, 8'h0c, 32'h0);
    chk("count", {28'h0, q[7:4]}, 32'h0);
    por(32'h313);
    wrun(30, 1'b0);
    por(32'h303);
    wrun(30, 1'b1);
    // slow fault logic misses the first check window, so the
    // sequencer retries once after a fresh delay and then resumes
    slow <= 1'b1;
    fpulse();
    npul(120, 2);
    wrun(5, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
